// [rtl/rsp_pkg.sv]
// Shared constants, carriers and enumerations of the comms setpoint block.
package rsp_pkg;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic valid;
    logic port;
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } modbus_req_s;

  typedef struct packed {
    logic valid;
    logic exception;
    logic [7:0] code;
    logic [15:0] data;
  } modbus_rsp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } modbus_wr_s;

  typedef enum logic [1:0] {
    SRC_SETPOINT,
    SRC_PROCESS,
    SRC_OUTPUT,
    SRC_ERROR
  } bcast_src_e;

  typedef enum logic {
    BC_RUN,
    BC_HELD
  } bcast_state_e;

  // ***************************************************************
  // Protocol codes and register addresses
  // ***************************************************************
  localparam logic PORT_CONFIG = 1'b0;
  localparam logic PORT_FIELD = 1'b1;
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] FUNC_WRITE = 8'h06;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_COUNT = 8'h03;
  localparam logic [15:0] READ_COUNT_ONE = 16'h0001;
  localparam logic [7:0] SLAVE_ALL = 8'h00;
  localparam logic [15:0] DEST_MIN = 16'h0001;
  localparam logic [15:0] DEST_MAX = 16'h270F;

  localparam logic [15:0] ADDR_VALUE = 16'h001A;
  localparam logic [15:0] ADDR_OFFSET = 16'h001B;
  localparam logic [15:0] ADDR_FLAG = 16'h0114;
  localparam logic [15:0] ADDR_UPPER = 16'h0116;
  localparam logic [15:0] ADDR_LOWER = 16'h0117;

  // ***************************************************************
  // Values after reset
  // ***************************************************************
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_FLAG = 16'h0000;
  localparam logic [15:0] RST_UPPER = 16'h7FFF;
  localparam logic [15:0] RST_LOWER = 16'h8000;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam longint unsigned CLK_HZ = 64'd50000000;
  localparam longint unsigned CYCLE_MS = 64'd250;
  localparam longint unsigned FAIL_MS = 64'd5000;
  localparam longint unsigned QUIET_MS = 64'd30000;
  localparam logic [31:0] CYCLE_CLKS = 32'(CLK_HZ * CYCLE_MS / 64'd1000);
  localparam logic [31:0] FAIL_CLKS = 32'(CLK_HZ * FAIL_MS / 64'd1000);
  localparam logic [31:0] QUIET_CLKS = 32'(CLK_HZ * QUIET_MS / 64'd1000);

endpackage

// [rtl/interval_timer.sv]
// Cycle counter that flags the end of a programmed interval.
`timescale 1ns/1ps
module interval_timer #(
  parameter logic [31:0] LIMIT = 32'h0000_0010,
  parameter logic PERIODIC = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Control
  input wire logic restart_in,
  // Status
  output logic done_out,
  output logic expired_out
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;
  logic expired_ff;
  logic nxt_expired;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_expired = expired_ff;
    if (restart_in)
    begin
      nxt_cnt = 32'h0000_0000;
      nxt_expired = 1'b0;
    end
    else if (!expired_ff)
    begin
      if (cnt_ff >= LIMIT - 32'h0000_0001)
      begin
        nxt_done = 1'b1;
        nxt_cnt = 32'h0000_0000;
        nxt_expired = !PERIODIC;
      end
      else
      begin
        nxt_cnt = cnt_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
      expired_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      expired_ff <= nxt_expired;
    end
  end

  assign done_out = done_ff;
  assign expired_out = expired_ff;

endmodule

// [rtl/modbus_comms_remote_setpoint.sv]
// Request decode, remote setpoint registers and broadcast master.
`timescale 1ns/1ps
module modbus_comms_remote_setpoint #(
  parameter logic [31:0] CYCLE_CLKS = rsp_pkg::CYCLE_CLKS,
  parameter logic [31:0] FAIL_CLKS = rsp_pkg::FAIL_CLKS,
  parameter logic [31:0] QUIET_CLKS = rsp_pkg::QUIET_CLKS
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Decoded requests and answers
  input wire rsp_pkg::modbus_req_s REQ_IN,
  output rsp_pkg::modbus_rsp_s RSP_OUT,
  // Configuration
  input wire logic PORT_SELECT_IN,
  input wire logic [7:0] DEVICE_ADDR_IN,
  input wire logic BCAST_ENABLE_IN,
  input wire rsp_pkg::bcast_src_e BCAST_SOURCE_IN,
  input wire logic [15:0] BCAST_DEST_IN,
  // Process quantities, scaled integers
  input wire logic [15:0] SETPOINT_IN,
  input wire logic [15:0] PROCESS_IN,
  input wire logic [15:0] OUTPUT_IN,
  input wire logic [15:0] ERROR_IN,
  // Broadcast write frames
  output rsp_pkg::modbus_wr_s BCAST_OUT,
  // Setpoint and status
  output logic [15:0] REMOTE_SP_OUT,
  output logic REMOTE_SP_ACTIVE_OUT,
  output logic REMOTE_FAIL_OUT,
  output logic BCAST_HELD_OUT
);

  // ***************************************************************
  // State
  // ***************************************************************
  logic [15:0] value_ff, nxt_value;
  logic [15:0] offset_ff, nxt_offset;
  logic [15:0] flag_ff, nxt_flag;
  logic [15:0] upper_ff, nxt_upper;
  logic [15:0] lower_ff, nxt_lower;
  rsp_pkg::modbus_rsp_s rsp_ff, nxt_rsp;
  rsp_pkg::modbus_wr_s bcast_ff, nxt_bcast;
  logic [15:0] sp_ff, nxt_sp;
  logic active_ff, nxt_active;
  logic fail_ff, nxt_fail;
  rsp_pkg::bcast_state_e state_ff, nxt_state;
  logic held_ff, nxt_held;

  logic hit, to_me, to_all, mapped, wr_ok, value_wr, field_me;
  logic [15:0] rd_data;
  logic signed [16:0] sum;
  logic tick, fail_expired, quiet_done;
  logic [15:0] src_val;

  // ***************************************************************
  // Timers
  // ***************************************************************
  // Holding the cycle timer in restart while disabled makes the first
  // broadcast come a full cycle after enabling, never a stale early one.
  interval_timer #(.LIMIT(CYCLE_CLKS), .PERIODIC(1'b1)) cycle_timer (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .restart_in(!BCAST_ENABLE_IN),
    .done_out(tick),
    .expired_out()
  );

  interval_timer #(.LIMIT(FAIL_CLKS), .PERIODIC(1'b0)) fail_timer (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .restart_in(value_wr),
    .done_out(),
    .expired_out(fail_expired)
  );

  interval_timer #(.LIMIT(QUIET_CLKS), .PERIODIC(1'b0)) quiet_timer (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .restart_in(field_me),
    .done_out(quiet_done),
    .expired_out()
  );

  // ***************************************************************
  // Request decode
  // ***************************************************************
  always_comb
  begin
    hit = REQ_IN.valid && (REQ_IN.port == PORT_SELECT_IN);
    to_me = hit && (REQ_IN.slave == DEVICE_ADDR_IN);
    to_all = hit && (REQ_IN.slave == rsp_pkg::SLAVE_ALL);
    field_me = to_me && (REQ_IN.port == rsp_pkg::PORT_FIELD);
    mapped = 1'b1;
    rd_data = 16'h0000;
    case (REQ_IN.addr)
      rsp_pkg::ADDR_VALUE: rd_data = value_ff;
      rsp_pkg::ADDR_OFFSET: rd_data = offset_ff;
      rsp_pkg::ADDR_FLAG: rd_data = flag_ff;
      rsp_pkg::ADDR_UPPER: rd_data = upper_ff;
      rsp_pkg::ADDR_LOWER: rd_data = lower_ff;
      default: mapped = 1'b0;
    endcase
    wr_ok = (to_me || to_all) && mapped
      && (REQ_IN.func == rsp_pkg::FUNC_WRITE);
    value_wr = wr_ok && (REQ_IN.addr == rsp_pkg::ADDR_VALUE);
  end

  // ***************************************************************
  // Registers and answers
  // ***************************************************************
  always_comb
  begin
    nxt_value = value_ff;
    nxt_offset = offset_ff;
    nxt_flag = flag_ff;
    nxt_upper = upper_ff;
    nxt_lower = lower_ff;
    nxt_rsp = '0;
    // The only write path into these registers is the request port.
    if (wr_ok)
    begin
      case (REQ_IN.addr)
        rsp_pkg::ADDR_VALUE: nxt_value = REQ_IN.data;
        rsp_pkg::ADDR_OFFSET: nxt_offset = REQ_IN.data;
        rsp_pkg::ADDR_FLAG: nxt_flag = REQ_IN.data;
        rsp_pkg::ADDR_UPPER: nxt_upper = REQ_IN.data;
        rsp_pkg::ADDR_LOWER: nxt_lower = REQ_IN.data;
        default: nxt_value = value_ff;
      endcase
    end
    // Writes to every slave are applied silently.
    if (to_me)
    begin
      nxt_rsp.valid = 1'b1;
      nxt_rsp.code = REQ_IN.func;
      if (REQ_IN.func != rsp_pkg::FUNC_READ
        && REQ_IN.func != rsp_pkg::FUNC_WRITE)
      begin
        nxt_rsp.exception = 1'b1;
        nxt_rsp.code = rsp_pkg::EXC_FUNC;
      end
      else if (!mapped)
      begin
        nxt_rsp.exception = 1'b1;
        nxt_rsp.code = rsp_pkg::EXC_ADDR;
      end
      else if (REQ_IN.func == rsp_pkg::FUNC_READ)
      begin
        if (REQ_IN.data != rsp_pkg::READ_COUNT_ONE)
        begin
          nxt_rsp.exception = 1'b1;
          nxt_rsp.code = rsp_pkg::EXC_COUNT;
        end
        else
        begin
          nxt_rsp.data = rd_data;
        end
      end
      else
      begin
        nxt_rsp.data = REQ_IN.data;
      end
    end
  end

  // ***************************************************************
  // Remote setpoint
  // ***************************************************************
  always_comb
  begin
    sum = $signed({value_ff[15], value_ff})
      + $signed({offset_ff[15], offset_ff});
    nxt_sp = sum[15:0];
    // A 17-bit sum never wraps, so an offset cannot flip the sign.
    if (sum > $signed({upper_ff[15], upper_ff}))
    begin
      nxt_sp = upper_ff;
    end
    else if (sum < $signed({lower_ff[15], lower_ff}))
    begin
      nxt_sp = lower_ff;
    end
    nxt_fail = (flag_ff != 16'h0000) && fail_expired;
    nxt_active = (flag_ff != 16'h0000) && !nxt_fail;
  end

  // ***************************************************************
  // Broadcast master
  // ***************************************************************
  always_comb
  begin
    case (BCAST_SOURCE_IN)
      rsp_pkg::SRC_SETPOINT: src_val = SETPOINT_IN;
      rsp_pkg::SRC_PROCESS: src_val = PROCESS_IN;
      rsp_pkg::SRC_OUTPUT: src_val = OUTPUT_IN;
      rsp_pkg::SRC_ERROR: src_val = ERROR_IN;
      default: src_val = SETPOINT_IN;
    endcase
    nxt_state = state_ff;
    case (state_ff)
      rsp_pkg::BC_RUN:
      begin
        if (field_me)
        begin
          nxt_state = rsp_pkg::BC_HELD;
        end
      end
      rsp_pkg::BC_HELD:
      begin
        // A fresh request in the expiry cycle keeps the hold.
        if (quiet_done && !field_me)
        begin
          nxt_state = rsp_pkg::BC_RUN;
        end
      end
      default: nxt_state = rsp_pkg::BC_RUN;
    endcase
    nxt_held = (nxt_state == rsp_pkg::BC_HELD);
    nxt_bcast = '0;
    if (tick && BCAST_ENABLE_IN && state_ff == rsp_pkg::BC_RUN
      && !field_me && PORT_SELECT_IN == rsp_pkg::PORT_FIELD
      && BCAST_DEST_IN >= rsp_pkg::DEST_MIN
      && BCAST_DEST_IN <= rsp_pkg::DEST_MAX)
    begin
      nxt_bcast.valid = 1'b1;
      nxt_bcast.slave = rsp_pkg::SLAVE_ALL;
      nxt_bcast.func = rsp_pkg::FUNC_WRITE;
      nxt_bcast.addr = BCAST_DEST_IN;
      nxt_bcast.data = src_val;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      value_ff <= rsp_pkg::RST_VALUE;
      offset_ff <= rsp_pkg::RST_OFFSET;
      flag_ff <= rsp_pkg::RST_FLAG;
      upper_ff <= rsp_pkg::RST_UPPER;
      lower_ff <= rsp_pkg::RST_LOWER;
      rsp_ff <= '0;
      bcast_ff <= '0;
      sp_ff <= 16'h0000;
      active_ff <= 1'b0;
      fail_ff <= 1'b0;
      state_ff <= rsp_pkg::BC_RUN;
      held_ff <= 1'b0;
    end
    else
    begin
      value_ff <= nxt_value;
      offset_ff <= nxt_offset;
      flag_ff <= nxt_flag;
      upper_ff <= nxt_upper;
      lower_ff <= nxt_lower;
      rsp_ff <= nxt_rsp;
      bcast_ff <= nxt_bcast;
      sp_ff <= nxt_sp;
      active_ff <= nxt_active;
      fail_ff <= nxt_fail;
      state_ff <= nxt_state;
      held_ff <= nxt_held;
    end
  end

  assign RSP_OUT = rsp_ff;
  assign BCAST_OUT = bcast_ff;
  assign REMOTE_SP_OUT = sp_ff;
  assign REMOTE_SP_ACTIVE_OUT = active_ff;
  assign REMOTE_FAIL_OUT = fail_ff;
  assign BCAST_HELD_OUT = held_ff;

endmodule

// [test/modbus_comms_remote_setpoint_asserts.sv]
// Assertion checker bound to the comms setpoint block.
`timescale 1ns/1ps
module modbus_comms_remote_setpoint_asserts #(
  parameter logic [31:0] CYCLE_CLKS = rsp_pkg::CYCLE_CLKS,
  parameter logic [31:0] FAIL_CLKS = rsp_pkg::FAIL_CLKS,
  parameter logic [31:0] QUIET_CLKS = rsp_pkg::QUIET_CLKS
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Requests and answers
  input wire rsp_pkg::modbus_req_s REQ_IN,
  input wire rsp_pkg::modbus_rsp_s RSP_OUT,
  // Configuration
  input wire logic PORT_SELECT_IN,
  input wire logic [7:0] DEVICE_ADDR_IN,
  input wire logic BCAST_ENABLE_IN,
  input wire rsp_pkg::bcast_src_e BCAST_SOURCE_IN,
  input wire logic [15:0] BCAST_DEST_IN,
  // Process quantities
  input wire logic [15:0] SETPOINT_IN,
  input wire logic [15:0] PROCESS_IN,
  input wire logic [15:0] OUTPUT_IN,
  input wire logic [15:0] ERROR_IN,
  // Outputs
  input wire rsp_pkg::modbus_wr_s BCAST_OUT,
  input wire logic [15:0] REMOTE_SP_OUT,
  input wire logic REMOTE_SP_ACTIVE_OUT,
  input wire logic REMOTE_FAIL_OUT,
  input wire logic BCAST_HELD_OUT
);
  logic to_me;
  logic sp_write;
  logic [15:0] pick;
  logic [31:0] gap_ff;
  logic [31:0] nxt_gap;
  logic [31:0] quiet_ff;
  logic [31:0] nxt_quiet;

  // *****************************************
  // Helper logic
  // *****************************************
  always_comb
  begin
    to_me = REQ_IN.valid && (REQ_IN.port == PORT_SELECT_IN)
      && (REQ_IN.slave == DEVICE_ADDR_IN);
    sp_write = REQ_IN.valid && (REQ_IN.port == PORT_SELECT_IN)
      && (REQ_IN.func == rsp_pkg::FUNC_WRITE)
      && (REQ_IN.addr == rsp_pkg::ADDR_VALUE)
      && ((REQ_IN.slave == DEVICE_ADDR_IN)
      || (REQ_IN.slave == rsp_pkg::SLAVE_ALL));
    case (BCAST_SOURCE_IN)
      rsp_pkg::SRC_SETPOINT: pick = SETPOINT_IN;
      rsp_pkg::SRC_PROCESS: pick = PROCESS_IN;
      rsp_pkg::SRC_OUTPUT: pick = OUTPUT_IN;
      default: pick = ERROR_IN;
    endcase
    nxt_gap = BCAST_OUT.valid ? 32'h0 : gap_ff + 32'h1;
    nxt_quiet = sp_write ? 32'h0 : quiet_ff + 32'h1;
  end

  // The gap starts full so the first frame after reset is never flagged.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      gap_ff <= CYCLE_CLKS;
      quiet_ff <= 32'h0;
    end
    else
    begin
      gap_ff <= nxt_gap;
      quiet_ff <= nxt_quiet;
    end
  end

  // *****************************************
  // Properties
  // *****************************************
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  a_rsp_has_cause:
    assert property (RSP_OUT.valid |-> $past(to_me))
    else $error("Answer with no request taken on the live port.");
  a_req_answered:
    assert property (to_me |=> RSP_OUT.valid)
    else $error("Request to this device got no answer.");
  a_bcast_form:
    assert property (BCAST_OUT.valid |-> (BCAST_OUT.slave == 8'h00)
      && (BCAST_OUT.func == 8'h06))
    else $error("Broadcast frame with wrong slave or function.");
  a_bcast_dest:
    assert property (BCAST_OUT.valid |->
      (BCAST_OUT.addr == $past(BCAST_DEST_IN))
      && (BCAST_OUT.addr >= 16'h0001) && (BCAST_OUT.addr <= 16'h270F))
    else $error("Broadcast destination wrong or out of range.");
  a_bcast_value:
    assert property (BCAST_OUT.valid |-> BCAST_OUT.data == $past(pick))
    else $error("Broadcast data is not the selected quantity.");
  a_field_holds:
    assert property (to_me && (REQ_IN.port == rsp_pkg::PORT_FIELD)
      |=> BCAST_HELD_OUT && !BCAST_OUT.valid)
    else $error("Field request did not inhibit broadcasts.");
  a_bcast_spacing:
    assert property (BCAST_OUT.valid |-> gap_ff >= CYCLE_CLKS - 32'h1)
    else $error("Two broadcasts inside one control cycle.");
  a_fail_quiet:
    assert property ($rose(REMOTE_FAIL_OUT) |-> quiet_ff >= FAIL_CLKS)
    else $error("Remote fail raised before the timeout elapsed.");
  a_fail_clears:
    assert property (sp_write |-> ##2 !REMOTE_FAIL_OUT)
    else $error("Remote fail still set after a setpoint write.");
  a_bcast_gated:
    assert property (BCAST_OUT.valid |-> $past(BCAST_ENABLE_IN)
      && ($past(PORT_SELECT_IN) == rsp_pkg::PORT_FIELD)
      && !$past(BCAST_HELD_OUT))
    else $error("Broadcast sent while disabled, held or off the field port.");
  a_active_no_fail:
    assert property (REMOTE_SP_ACTIVE_OUT |-> !REMOTE_FAIL_OUT)
    else $error("Remote setpoint active while remote fail is set.");
endmodule

bind modbus_comms_remote_setpoint modbus_comms_remote_setpoint_asserts #(
  .CYCLE_CLKS(CYCLE_CLKS),
  .FAIL_CLKS(FAIL_CLKS),
  .QUIET_CLKS(QUIET_CLKS)
) u_modbus_comms_remote_setpoint_asserts (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .REQ_IN(REQ_IN),
  .RSP_OUT(RSP_OUT), .PORT_SELECT_IN(PORT_SELECT_IN),
  .DEVICE_ADDR_IN(DEVICE_ADDR_IN), .BCAST_ENABLE_IN(BCAST_ENABLE_IN),
  .BCAST_SOURCE_IN(BCAST_SOURCE_IN), .BCAST_DEST_IN(BCAST_DEST_IN),
  .SETPOINT_IN(SETPOINT_IN), .PROCESS_IN(PROCESS_IN),
  .OUTPUT_IN(OUTPUT_IN), .ERROR_IN(ERROR_IN), .BCAST_OUT(BCAST_OUT),
  .REMOTE_SP_OUT(REMOTE_SP_OUT),
  .REMOTE_SP_ACTIVE_OUT(REMOTE_SP_ACTIVE_OUT),
  .REMOTE_FAIL_OUT(REMOTE_FAIL_OUT), .BCAST_HELD_OUT(BCAST_HELD_OUT)
);

// [test/rsp_master_model.sv]
// Behavioural field master that hands decoded requests to the block.
`timescale 1ns/1ps
module rsp_master_model (
  // Clock
  input wire logic clk_in,
  // Requests toward the block
  output rsp_pkg::modbus_req_s req_out
);
  initial
  begin
    req_out = '0;
  end

  // Broadcast frames are never answered from here.
  // Idle fields carry noise, so a design that ignores valid is caught.
  task automatic issue(input logic port, input logic [7:0] slave,
    input logic [7:0] func, input logic [15:0] addr,
    input logic [15:0] data);
    @(posedge clk_in);
    req_out <= {1'b1, port, slave, func, addr, data};
    @(posedge clk_in);
    req_out <= {1'b0, 17'($urandom), 32'($urandom)};
  endtask
endmodule

// [test/modbus_comms_remote_setpoint_bench.sv]
// Self-checking bench for the comms setpoint block.
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
    end \
  end
module modbus_comms_remote_setpoint_bench;
  localparam logic [31:0] CYC = 32'h14;
  localparam logic [31:0] FAIL = 32'h64;
  localparam logic [31:0] QUIET = 32'hC8;
  logic clk;
  logic reset_n;
  rsp_pkg::modbus_req_s req;
  rsp_pkg::modbus_rsp_s rsp;
  rsp_pkg::modbus_wr_s bc;
  logic port_sel;
  logic [7:0] dev;
  logic bc_en;
  rsp_pkg::bcast_src_e src;
  logic [15:0] dest;
  logic [15:0] qty[4];
  logic [15:0] rem_sp;
  logic active;
  logic fail;
  logic held;
  logic [15:0] v;
  logic [24:0] got_rsp;
  logic [24:0] exp_rsp;
  logic [24:0] exp_q[$];
  int err_total;
  int checks_done;
  int frames;
  int n0;
  logic [15:0] addrs[5] = '{rsp_pkg::ADDR_VALUE, rsp_pkg::ADDR_OFFSET,
    rsp_pkg::ADDR_FLAG, rsp_pkg::ADDR_UPPER, rsp_pkg::ADDR_LOWER};
  logic [15:0] rsts[5] = '{rsp_pkg::RST_VALUE, rsp_pkg::RST_OFFSET,
    rsp_pkg::RST_FLAG, rsp_pkg::RST_UPPER, rsp_pkg::RST_LOWER};
  logic [47:0] cases[3] = '{48'h0050_001E_0064, 48'h0050_FF38_FFCE,
    48'h000A_FFFB_0005};
  logic [15:0] dests[6] = '{16'h0001, 16'h270F, 16'h0064, 16'h1000,
    16'h0000, 16'h2710};

  modbus_comms_remote_setpoint #(
    .CYCLE_CLKS(CYC),
    .FAIL_CLKS(FAIL),
    .QUIET_CLKS(QUIET)
  ) u_modbus_comms_remote_setpoint (
    .CLK_IN(clk), .RESET_N_IN(reset_n), .REQ_IN(req), .RSP_OUT(rsp),
    .PORT_SELECT_IN(port_sel), .DEVICE_ADDR_IN(dev),
    .BCAST_ENABLE_IN(bc_en), .BCAST_SOURCE_IN(src), .BCAST_DEST_IN(dest),
    .SETPOINT_IN(qty[0]), .PROCESS_IN(qty[1]), .OUTPUT_IN(qty[2]),
    .ERROR_IN(qty[3]), .BCAST_OUT(bc), .REMOTE_SP_OUT(rem_sp),
    .REMOTE_SP_ACTIVE_OUT(active), .REMOTE_FAIL_OUT(fail),
    .BCAST_HELD_OUT(held)
  );

  rsp_master_model u_rsp_master_model (
    .clk_in(clk),
    .req_out(req)
  );

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] d, input logic [24:0] e);
    exp_q.push_back(e);
    u_rsp_master_model.issue(port_sel, dev, f, a, d);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    xfer(rsp_pkg::FUNC_WRITE, a, d, {1'b0, rsp_pkg::FUNC_WRITE, d});
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    xfer(rsp_pkg::FUNC_READ, a, rsp_pkg::READ_COUNT_ONE,
      {1'b0, rsp_pkg::FUNC_READ, e});
  endtask

  // *****************************************
  // Result watcher
  // *****************************************
  // Frames are counted by non-blocking update so reads at an edge are stable.
  always @(posedge clk)
  begin
    if (rsp.valid === 1'b1)
    begin
      got_rsp = {rsp.exception, rsp.code,
        rsp.exception ? 16'h0000 : rsp.data};
      if (exp_q.size() == 0)
        `CHECK(rsp.valid, 1'b0)
      else
      begin
        exp_rsp = exp_q.pop_front();
        `CHECK(got_rsp, exp_rsp)
      end
    end
    if (bc.valid === 1'b1)
    begin
      frames <= frames + 1;
      `CHECK({bc.slave, bc.func}, 16'h0006)
      `CHECK(bc.addr, dest)
      `CHECK(bc.data, qty[src])
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #1000000;
    err_total++;
    end_of_test();
  end

  // *****************************************
  // Main sequence
  // *****************************************
  initial
  begin
    reset_n = 1'b0;
    port_sel = rsp_pkg::PORT_CONFIG;
    dev = 8'h11;
    bc_en = 1'b0;
    src = rsp_pkg::SRC_SETPOINT;
    dest = 16'h0001;
    err_total = 0;
    checks_done = 0;
    frames = 0;
    void'($urandom(11));
    foreach (qty[i]) qty[i] = 16'($urandom);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], rsts[i]);
    for (int j = 0; j < 2; j++)
      foreach (addrs[i])
      begin
        v = 16'($urandom);
        wr(addrs[i], v);
        rd(addrs[i], v);
      end
    xfer(8'h10, rsp_pkg::ADDR_VALUE, 16'h0000,
      {1'b1, rsp_pkg::EXC_FUNC, 16'h0000});
    xfer(rsp_pkg::FUNC_WRITE, 16'h001C, v,
      {1'b1, rsp_pkg::EXC_ADDR, 16'h0000});
    xfer(rsp_pkg::FUNC_READ, rsp_pkg::ADDR_FLAG, 16'h0002,
      {1'b1, rsp_pkg::EXC_COUNT, 16'h0000});
    u_rsp_master_model.issue(port_sel, rsp_pkg::SLAVE_ALL,
      rsp_pkg::FUNC_WRITE, rsp_pkg::ADDR_OFFSET, 16'h0007);
    u_rsp_master_model.issue(~port_sel, dev, rsp_pkg::FUNC_WRITE,
      rsp_pkg::ADDR_OFFSET, 16'h1234);
    u_rsp_master_model.issue(port_sel, 8'h12, rsp_pkg::FUNC_WRITE,
      rsp_pkg::ADDR_OFFSET, 16'h4321);
    rd(rsp_pkg::ADDR_OFFSET, 16'h0007);
    wr(rsp_pkg::ADDR_FLAG, 16'h0000);
    cycles(3);
    `CHECK(active, 1'b0)
    wr(rsp_pkg::ADDR_FLAG, 16'h0001);
    wr(rsp_pkg::ADDR_UPPER, 16'h0064);
    wr(rsp_pkg::ADDR_LOWER, 16'hFFCE);
    foreach (cases[i])
    begin
      wr(rsp_pkg::ADDR_VALUE, cases[i][47:32]);
      wr(rsp_pkg::ADDR_OFFSET, cases[i][31:16]);
      cycles(3);
      `CHECK(rem_sp, cases[i][15:0])
      `CHECK(active, 1'b1)
    end
    repeat (3)
    begin
      cycles(60);
      wr(rsp_pkg::ADDR_VALUE, 16'h000A);
    end
    `CHECK(fail, 1'b0)
    cycles(int'(FAIL) + 8);
    `CHECK(fail, 1'b1)
    `CHECK(active, 1'b0)
    wr(rsp_pkg::ADDR_VALUE, 16'h000B);
    cycles(3);
    `CHECK(fail, 1'b0)
    frames = 0;
    bc_en <= 1'b1;
    cycles(2 * int'(CYC) + 5);
    bc_en <= 1'b0;
    `CHECK(frames, 0)
    port_sel <= rsp_pkg::PORT_FIELD;
    foreach (dests[i])
    begin
      cycles(3);
      frames = 0;
      dest <= dests[i];
      src <= rsp_pkg::bcast_src_e'(i[1:0]);
      bc_en <= 1'b1;
      cycles(4 * int'(CYC) + 5);
      bc_en <= 1'b0;
      cycles(3);
      `CHECK(frames, (i < 4) ? 4 : 0)
    end
    dest <= 16'h0001;
    bc_en <= 1'b1;
    cycles(2 * int'(CYC));
    rd(rsp_pkg::ADDR_VALUE, 16'h000B);
    cycles(2);
    `CHECK(held, 1'b1)
    n0 = frames;
    cycles(int'(QUIET) - 20);
    `CHECK(frames, n0)
    cycles(40);
    `CHECK(held, 1'b0)
    n0 = frames;
    cycles(2 * int'(CYC));
    `CHECK(frames, n0 + 2)
    `CHECK(exp_q.size(), 0)
    end_of_test();
  end
endmodule
